// ### core/bdm_decoder.sv
// Banked data memory decoder with mirrored core registers and folded bank 1
// Functional notes
// - Status bits 6:5 pick bank 0 to 3 for every direct access.
// - Each bank holds 128 byte locations reached by a 7-bit offset.
// - Low offsets decode to core registers, higher offsets to general RAM; the small variant has no RAM above 2Fh.
// - Core registers such as program counter low are one register in all banks.
// - General RAM is reached directly or through the indirect pointer.
// - In the small variant, bank 1 offsets 0Ch-2Fh reach bank 0 RAM.
`timescale 1ns/1ps
module bdm_decoder
    import bdm_pkg::*;
#(
    parameter int NUM_BANKS = 4,
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [6:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    output logic [1:0] bankSelect,
    output logic [7:0] indirectPointer,
    output logic [7:0] programCounterLowByte
);
    // Only counts that the two bank bits can split evenly are served
    initial begin
        if (NUM_BANKS != 1 && NUM_BANKS != 2 && NUM_BANKS != 4) begin
            $error("NUM_BANKS must be 1, 2 or 4");
        end
    end

    logic [7:0] status;
    logic [7:0] pointer;
    logic [7:0] pcLow;
    logic [7:0] pcUpper;
    logic [7:0] intCtrl;
    logic [7:0] next_status;
    logic [7:0] next_pointer;
    logic [7:0] next_pcLow;
    logic [7:0] next_pcUpper;
    logic [7:0] next_intCtrl;
    logic [7:0] next_rdData;
    logic [8:0] directAddr;
    logic [8:0] indirectAddr;
    bdm_decode_t dec;
    logic ramWe;
    logic [7:0] ramData;

    // Full address of a location: bank number over in-bank offset
    function automatic bdm_decode_t decode(input logic [8:0] a);
        bdm_decode_t d;
        logic [1:0] bank;
        logic [6:0] ofs;
        d = '{target: BDM_T_NONE, ramAddr: a};
        bank = a[8:7];
        ofs = a[6:0];
        // Core registers decode in every bank code, so a missing bank never locks out status
        if (ofs == BDM_OFS_INDIRECT) begin
            d.target = BDM_T_INDIRECT;
        end else if (ofs == BDM_OFS_PC_LOW) begin
            d.target = BDM_T_PC_LOW;
        end else if (ofs == BDM_OFS_STATUS) begin
            d.target = BDM_T_STATUS;
        end else if (ofs == BDM_OFS_POINTER) begin
            d.target = BDM_T_POINTER;
        end else if (ofs == BDM_OFS_PC_UPPER) begin
            d.target = BDM_T_PC_UPPER;
        end else if (ofs == BDM_OFS_INT_CTRL) begin
            d.target = BDM_T_INT_CTRL;
        end else if (int'(bank) >= NUM_BANKS) begin
            d.target = BDM_T_NONE;
        end else if (SMALL_VARIANT && ofs >= BDM_FOLD_FIRST && ofs <= BDM_FOLD_LAST
                     && bank != 2'b00) begin
            // Folded range has no storage; reach bank 0 instead
            d.target = BDM_T_GPR;
            d.ramAddr = {2'b00, ofs};
        end else if (SMALL_VARIANT && ofs >= BDM_FOLD_FIRST && ofs <= BDM_FOLD_LAST) begin
            d.target = BDM_T_GPR;
        end else if (ofs >= BDM_GPR_START && !(SMALL_VARIANT && ofs > BDM_FOLD_LAST)) begin
            d.target = BDM_T_GPR;
        end else begin
            // Peripheral registers live outside this block and read zero here
            d.target = BDM_T_NONE;
        end
        return d;
    endfunction

    assign bankSelect = {status[BDM_BANK_HI_POS], status[BDM_BANK_LO_POS]};
    assign directAddr = {bankSelect, addr};
    // Pointer bit 7 picks the odd bank; the high bank bit comes from status bit 7
    assign indirectAddr = {status[7], pointer};
    assign dec = (addr == BDM_OFS_INDIRECT) ? decode(indirectAddr) : decode(directAddr);
    assign indirectPointer = pointer;
    assign programCounterLowByte = pcLow;

    // The indirect port reached through itself is a null access, never a loop
    assign ramWe = wrStrobe && dec.target == BDM_T_GPR;

    bdm_gpr_ram #(
        .DEPTH(512)
    ) u_ram (
        .clk_sys(clk_sys),
        .we(ramWe),
        .waddr(dec.ramAddr),
        .wdata(wrData),
        .raddr(dec.ramAddr),
        .rdata(ramData)
    );

    // Read data falls back to zero so the core never sees a stale byte
    always_comb begin
        next_status = status;
        next_pointer = pointer;
        next_pcLow = pcLow;
        next_pcUpper = pcUpper;
        next_intCtrl = intCtrl;
        next_rdData = 8'h00;
        if (wrStrobe) begin
            unique case (dec.target)
                BDM_T_STATUS: next_status = wrData;
                BDM_T_POINTER: next_pointer = wrData;
                BDM_T_PC_LOW: next_pcLow = wrData;
                BDM_T_PC_UPPER: next_pcUpper = wrData;
                BDM_T_INT_CTRL: next_intCtrl = wrData;
                default: next_status = status;
            endcase
        end
        if (rdStrobe) begin
            unique case (dec.target)
                BDM_T_STATUS: next_rdData = status;
                BDM_T_POINTER: next_rdData = pointer;
                BDM_T_PC_LOW: next_rdData = pcLow;
                BDM_T_PC_UPPER: next_rdData = pcUpper;
                BDM_T_INT_CTRL: next_rdData = intCtrl;
                BDM_T_GPR: next_rdData = ramData;
                default: next_rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // Reset returns bank 0 so the core starts in a known map
            status <= BDM_STATUS_RESET;
            pointer <= BDM_POINTER_RESET;
            pcLow <= BDM_PC_LOW_RESET;
            pcUpper <= BDM_PC_UPPER_RESET;
            intCtrl <= BDM_INT_CTRL_RESET;
            rdData <= 8'h00;
        end else begin
            status <= next_status;
            pointer <= next_pointer;
            pcLow <= next_pcLow;
            pcUpper <= next_pcUpper;
            intCtrl <= next_intCtrl;
            rdData <= next_rdData;
        end
    end

    // Checks below watch only what this block drives
    bank_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrStrobe && addr == BDM_OFS_STATUS |=> bankSelect == $past(wrData[6:5]))
        else $error("bank select did not follow status write");

    mirror_pc_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrStrobe && addr == BDM_OFS_PC_LOW |=> programCounterLowByte == $past(wrData))
        else $error("program counter low not shared across banks");

    mirror_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        rdStrobe && addr == BDM_OFS_STATUS |=> rdData == $past(status))
        else $error("status read mismatch");

    no_read_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        !rdStrobe |=> rdData == 8'h00)
        else $error("read data not zero outside read");

    gpr_round_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrStrobe && dec.target == BDM_T_GPR ##1 rdStrobe && !wrStrobe
        && dec.ramAddr == $past(dec.ramAddr) |=> rdData == $past(wrData, 2))
        else $error("general register lost written value");

    fold_map_a: assert property (@(posedge clk_sys) disable iff (rst)
        SMALL_VARIANT && addr != BDM_OFS_INDIRECT && bankSelect == 2'b01
        && addr >= BDM_FOLD_FIRST && addr <= BDM_FOLD_LAST |-> dec.ramAddr[8:7] == 2'b00)
        else $error("folded range not mapped to bank 0");

    unmapped_a: assert property (@(posedge clk_sys) disable iff (rst)
        rdStrobe && dec.target == BDM_T_NONE |=> rdData == 8'h00)
        else $error("unmapped read not zero");

    indirect_a: assert property (@(posedge clk_sys) disable iff (rst)
        addr == BDM_OFS_INDIRECT && pointer[6:0] >= BDM_GPR_START
        && int'({status[7], pointer[7]}) < NUM_BANKS
        |-> dec.ramAddr == ((SMALL_VARIANT && pointer[6:0] <= BDM_FOLD_LAST
        && {status[7], pointer[7]} != 2'b00) ? {2'b00, pointer[6:0]} : {status[7], pointer}))
        else $error("indirect address wrong");

    pointer_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrStrobe && addr == BDM_OFS_POINTER |=> indirectPointer == $past(wrData))
        else $error("pointer not shared across banks");

    refused_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrStrobe && dec.target == BDM_T_NONE |=> status == $past(status)
        && indirectPointer == $past(indirectPointer)
        && programCounterLowByte == $past(programCounterLowByte))
        else $error("refused write changed a core register");

    direct_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
        addr != BDM_OFS_INDIRECT && dec.target == BDM_T_GPR
        && (!SMALL_VARIANT || status[BDM_BANK_HI_POS:BDM_BANK_LO_POS] == 2'b00)
        |-> dec.ramAddr == {status[BDM_BANK_HI_POS:BDM_BANK_LO_POS], addr})
        else $error("direct address not bank over offset");

    bank_range_a: assert property (@(posedge clk_sys) disable iff (rst)
        rdStrobe && addr >= BDM_GPR_START && int'(bankSelect) >= NUM_BANKS |=> rdData == 8'h00)
        else $error("read of a missing bank not zero");

    self_indirect_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrStrobe && addr == BDM_OFS_INDIRECT && pointer[6:0] == BDM_OFS_INDIRECT |-> !ramWe)
        else $error("indirect port wrote through itself");
endmodule

// ### core/bdm_pkg.sv
// Package for the banked data memory decoder: map constants and carriers
package bdm_pkg;
    localparam int BDM_OFS_W = 7;
    localparam int BDM_ADDR_W = 9;
    localparam logic [6:0] BDM_OFS_INDIRECT = 7'h00;
    localparam logic [6:0] BDM_OFS_PC_LOW = 7'h02;
    localparam logic [6:0] BDM_OFS_STATUS = 7'h03;
    localparam logic [6:0] BDM_OFS_POINTER = 7'h04;
    localparam logic [6:0] BDM_OFS_PC_UPPER = 7'h0A;
    localparam logic [6:0] BDM_OFS_INT_CTRL = 7'h0B;
    localparam logic [6:0] BDM_OFS_LAST = 7'h7F;
    localparam int BDM_BANK_HI_POS = 6;
    localparam int BDM_BANK_LO_POS = 5;
    localparam logic [7:0] BDM_STATUS_RESET = 8'h18;
    localparam logic [7:0] BDM_POINTER_RESET = 8'h00;
    localparam logic [7:0] BDM_PC_LOW_RESET = 8'h00;
    localparam logic [7:0] BDM_PC_UPPER_RESET = 8'h00;
    localparam logic [7:0] BDM_INT_CTRL_RESET = 8'h00;
    localparam logic [6:0] BDM_GPR_START = 7'h20;
    localparam logic [6:0] BDM_FOLD_FIRST = 7'h0C;
    localparam logic [6:0] BDM_FOLD_LAST = 7'h2F;

    typedef enum logic [2:0] {
        BDM_T_NONE = 3'b000,
        BDM_T_INDIRECT = 3'b001,
        BDM_T_PC_LOW = 3'b010,
        BDM_T_STATUS = 3'b011,
        BDM_T_POINTER = 3'b100,
        BDM_T_PC_UPPER = 3'b101,
        BDM_T_INT_CTRL = 3'b110,
        BDM_T_GPR = 3'b111
    } bdm_target_t;

    typedef struct packed {
        bdm_target_t target;
        logic [8:0] ramAddr;
    } bdm_decode_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bdm_req_t;
endpackage

// ### core/bdm_gpr_ram.sv
// General purpose register static RAM
`timescale 1ns/1ps
module bdm_gpr_ram
    import bdm_pkg::*;
#(
    parameter int DEPTH = 512
) (
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [8:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [8:0] raddr,
    output logic [7:0] rdata
);
    initial begin
        if (DEPTH < 1 || DEPTH > 512) begin
            $error("DEPTH out of range");
        end
    end

    logic [7:0] mem [DEPTH];

    // Storage has no reset, as a real register file
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule

// ### bench/bdm_testbench.sv
// Self-checking bench for the banked data memory decoder, full and small variants
`timescale 1ns/1ps
`define CHK(g, e, m) begin testsRun++; if ((g) !== (e)) begin errorCnt++; \
    $display("MISMATCH %0t %s: got %h exp %h", $time, m, g, e); end end
module testbench
    import bdm_pkg::*;
;
    logic clk_sys;
    logic rst;
    logic wrStrobe;
    logic rdStrobe;
    logic [6:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic [7:0] smallRdData;
    logic [7:0] indirectPointer;
    logic [7:0] programCounterLowByte;
    logic [1:0] bankSelect;
    logic [1:0] smallBank;
    logic [7:0] got;
    logic [7:0] gotSmall;
    int errorCnt;
    int testsRun;

    bdm_decoder dut_u (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .bankSelect(bankSelect), .indirectPointer(indirectPointer),
        .programCounterLowByte(programCounterLowByte)
    );

    // Folded variant shares every input, so one bus cycle exercises both maps
    bdm_decoder #(.NUM_BANKS(2), .SMALL_VARIANT(1'b1)) dut_small_u (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(smallRdData),
        .bankSelect(smallBank), .indirectPointer(), .programCounterLowByte()
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Idle cycle after each strobe so no strobe is assigned twice in one step
    task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
        addr <= ofs;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [6:0] ofs);
        addr <= ofs;
        rdStrobe <= 1'b1;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        @(negedge clk_sys);
        got = rdData;
        gotSmall = smallRdData;
        @(negedge clk_sys);
        `CHK(rdData, 8'h00, "read data lingers")
        @(posedge clk_sys);
    endtask

    task automatic rdChk(input logic [6:0] ofs, input logic [7:0] exp, input string m);
        rd(ofs);
        `CHK(got, exp, m)
    endtask

    task automatic setBank(input logic [1:0] b, input logic hi);
        wr(BDM_OFS_STATUS, BDM_STATUS_RESET | {hi, b, 5'h00});
    endtask

    task automatic report_and_stop();
        $display("Counts: %0d compares, %0d mismatches", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        errorCnt = 0;
        testsRun = 0;
        rst = 1'b1;
        addr = 7'h00;
        wrData = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        `CHK(bankSelect, 2'b00, "bank after reset")
        `CHK(indirectPointer, BDM_POINTER_RESET, "pointer reset")
        `CHK(programCounterLowByte, BDM_PC_LOW_RESET, "pc low reset")
        rdChk(BDM_OFS_STATUS, BDM_STATUS_RESET, "status reset");
        $display("test reset done");
        // Distinct data per bank at a mid offset and at the last offset
        for (int b = 0; b < 4; b++) begin
            setBank(b[1:0], 1'b0);
            `CHK(bankSelect, b[1:0], "bank select")
            wr(7'h25, {6'h28, b[1:0]});
            wr(BDM_OFS_LAST, {6'h14, b[1:0]});
        end
        for (int b = 0; b < 4; b++) begin
            setBank(b[1:0], 1'b0);
            rdChk(7'h25, {6'h28, b[1:0]}, "gpr per bank");
            rdChk(BDM_OFS_LAST, {6'h14, b[1:0]}, "last offset");
        end
        $display("test banks done");
        setBank(2'd2, 1'b0);
        wr(BDM_OFS_PC_LOW, 8'h5A);
        `CHK(programCounterLowByte, 8'h5A, "pc low port")
        setBank(2'd1, 1'b0);
        rdChk(BDM_OFS_PC_LOW, 8'h5A, "pc low mirror");
        setBank(2'd3, 1'b0);
        wr(BDM_OFS_POINTER, 8'hA5);
        `CHK(indirectPointer, 8'hA5, "pointer port")
        setBank(2'd0, 1'b0);
        rdChk(BDM_OFS_POINTER, 8'hA5, "pointer mirror");
        $display("test mirror done");
        // Pointer A5 with high bit clear lands on bank 1 offset 25
        rdChk(BDM_OFS_INDIRECT, 8'hA1, "indirect low");
        setBank(2'd0, 1'b1);
        wr(BDM_OFS_POINTER, 8'h25);
        rdChk(BDM_OFS_INDIRECT, 8'hA2, "indirect high");
        setBank(2'd0, 1'b0);
        wr(BDM_OFS_POINTER, 8'hFF);
        wr(BDM_OFS_INDIRECT, 8'hC3);
        setBank(2'd1, 1'b0);
        rdChk(BDM_OFS_LAST, 8'hC3, "indirect write");
        $display("test indirect done");
        setBank(2'd0, 1'b0);
        wr(7'h01, 8'hFF);
        rdChk(7'h01, 8'h00, "unmapped write");
        rdChk(7'h1F, 8'h00, "unmapped read");
        $display("test unmapped done");
        // Write then read with no gap between strobes, as the core may issue them
        setBank(2'd2, 1'b0);
        addr <= 7'h40;
        wrData <= 8'h3C;
        wrStrobe <= 1'b1;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b1;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        @(negedge clk_sys);
        `CHK(rdData, 8'h3C, "write then read")
        @(posedge clk_sys);
        $display("test back to back done");
        wr(BDM_OFS_PC_UPPER, 8'h1E);
        wr(BDM_OFS_INT_CTRL, 8'hC1);
        wr(BDM_OFS_POINTER, 8'h80);
        wr(BDM_OFS_INDIRECT, 8'h99);
        setBank(2'd3, 1'b0);
        rdChk(BDM_OFS_PC_UPPER, 8'h1E, "pc upper mirror");
        rdChk(BDM_OFS_INT_CTRL, 8'hC1, "int ctrl mirror");
        rdChk(BDM_OFS_INDIRECT, 8'h00, "indirect loop");
        rdChk(BDM_OFS_STATUS, 8'h78, "status mirror");
        `CHK(gotSmall, 8'h78, "small status reachable")
        $display("test core regs done");
        // Bank 1 folded window and bank 0 must be the same storage
        setBank(2'd1, 1'b0);
        wr(BDM_FOLD_FIRST, 8'h77);
        setBank(2'd0, 1'b0);
        wr(BDM_FOLD_LAST, 8'h66);
        rd(BDM_FOLD_FIRST);
        `CHK(gotSmall, 8'h77, "fold first")
        setBank(2'd1, 1'b0);
        `CHK(smallBank, 2'b01, "small bank")
        rd(BDM_FOLD_LAST);
        `CHK(gotSmall, 8'h66, "fold last")
        `CHK(got, 8'h00, "full map no fold")
        $display("test fold done");
        report_and_stop();
    end
endmodule
